// [lbpwm_engine.sv]
// Twelve-channel PWM engine with divider, sync pin and Wishbone registers.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module lbpwm_engine
    import lbpwm_pkg::*;
(
    // Clock and reset.
    input  wire logic                i_core_clk,
    input  wire logic                i_rstn,
    // Wishbone classic slave.
    input  wire logic                i_wb_cyc,
    input  wire logic                i_wb_stb,
    input  wire logic                i_wb_we,
    input  wire logic [ADR_W-1:0]    i_wb_adr,
    input  wire logic [DAT_W-1:0]    i_wb_dat,
    input  wire logic [3:0]          i_wb_sel,
    output logic      [DAT_W-1:0]    o_wb_dat,
    output logic                     o_wb_ack,
    // Sync pin.
    input  wire logic                i_sync_in,
    output logic                     o_sync_out,
    output logic                     o_sync_oe,
    // Bypass switch controls, 1 means closed and LED off.
    output logic      [NUM_CH-1:0]   o_bypass_closed,
    output logic      [CNT_W-1:0]    o_period_count
);

    // Byte-lane merge of a bus write into a register image.
    function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_v,
                                               input logic [DAT_W-1:0] new_v,
                                               input logic [3:0]       sel);
        logic [DAT_W-1:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Terminal count of the power-of-two stage, two to the e minus one.
    function automatic logic [6:0] pow2_m1(input logic [2:0] e);
        return 7'((8'h01 << e) - 8'h01);
    endfunction

    // Bus side.
    logic                wb_req;
    logic                wb_wr;
    logic [1:0]          adr_bank;
    logic [3:0]          adr_idx;
    logic                adr_ch_ok;
    logic [DAT_W-1:0]    rd_d;

    logic                ack_q;
    logic [DAT_W-1:0]    rdat_q;
    lbpwm_div_type       div_q;
    logic [NUM_CH-1:0]   enable_q;
    logic                master_q;
    logic                cmd_sync;

    // Divider and counter.
    logic [6:0]          pre_cnt_q;
    logic [3:0]          dec_cnt_q;
    logic                pre_tick;
    logic                pwm_tick;
    logic [CNT_W-1:0]    cnt_q;
    logic [CNT_W-1:0]    cnt_d;
    logic                step;
    logic                sync_clr;

    // Sync pin.
    logic                sync_meta_q;
    logic                sync_s_q;
    logic                sync_prev_q;
    logic                sync_rise;
    logic                sync_out_q;

    // Channel state.
    logic [CNT_W-1:0]    on_act_q  [NUM_CH];
    logic [CNT_W-1:0]    off_act_q [NUM_CH];
    logic [CNT_W-1:0]    on_shd_q  [NUM_CH];
    logic [CNT_W-1:0]    off_shd_q [NUM_CH];
    logic [NUM_CH-1:0]   on_pend_q;
    logic [NUM_CH-1:0]   off_pend_q;
    logic [NUM_CH-1:0]   closed_q;
    logic [NUM_CH-1:0]   on_raw;
    logic [NUM_CH-1:0]   off_raw;

    // Bus decode; one wait state, ack in the cycle after the request.
    assign wb_req    = i_wb_cyc && i_wb_stb && !ack_q;
    assign wb_wr     = wb_req && i_wb_we;
    assign adr_bank  = i_wb_adr[7:6];
    assign adr_idx   = i_wb_adr[5:2];
    assign adr_ch_ok = (i_wb_adr[1:0] == 2'h0) && (adr_idx < 4'(NUM_CH));
    assign cmd_sync  = wb_wr && (i_wb_adr == OFS_SYNC_CMD) && i_wb_sel[0]
                       && i_wb_dat[SYNC_CMD_BIT];

    // Compare reads return the shadow, which is the last value written.
    always_comb begin
        rd_d = '0;
        if (adr_ch_ok && adr_bank == BANK_ON) begin
            rd_d[CNT_W-1:0] = on_shd_q[adr_idx];
        end else if (adr_ch_ok && adr_bank == BANK_OFF) begin
            rd_d[CNT_W-1:0] = off_shd_q[adr_idx];
        end else begin
            unique case (i_wb_adr)
                OFS_ENABLE:  rd_d[NUM_CH-1:0] = enable_q;
                OFS_DIVIDER: begin
                    rd_d[DIV_EXP_LSB +: DIV_EXP_W] = div_q.exp;
                    rd_d[DIV_DEC_LSB +: DIV_DEC_W] = div_q.dec_m1;
                end
                OFS_SYSTEM_CONFIGURATION:  rd_d[SYSTEM_CONFIGURATION_MASTER] = master_q;
                OFS_STATUS:  begin
                    rd_d[STAT_CNT_LSB +: CNT_W]  = cnt_q;
                    rd_d[STAT_SW_LSB +: NUM_CH]  = closed_q;
                end
                default:     rd_d = '0;
            endcase
        end
    end

    // A held strobe is taken again only after ack has dropped.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q  <= wb_req;
            if (wb_req) begin
                rdat_q <= rd_d;
            end
        end
    end

    // Configuration registers.
    // The sync pin direction follows the master bit with no extra delay.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q.exp    <= DIV_EXP_RESET; // [R8]
            div_q.dec_m1 <= DIV_DEC_RESET; // [R8]
            enable_q     <= ENABLE_RESET;
            master_q     <= 1'b0;
        end else if (wb_wr) begin
            unique case (i_wb_adr)
                OFS_ENABLE:  enable_q <= NUM_CH'(merge(32'(enable_q), i_wb_dat, i_wb_sel));
                OFS_DIVIDER: begin
                    if (i_wb_sel[0]) begin
                        div_q.exp <= i_wb_dat[DIV_EXP_LSB +: DIV_EXP_W];
                    end
                    if (i_wb_sel[1]) begin
                        div_q.dec_m1 <= i_wb_dat[DIV_DEC_LSB +: DIV_DEC_W];
                    end
                end
                OFS_SYSTEM_CONFIGURATION:  begin
                    if (i_wb_sel[0]) begin
                        master_q <= i_wb_dat[SYSTEM_CONFIGURATION_MASTER];
                    end
                end
                default:     ;
            endcase
        end
    end

    // Two-stage PWM clock divider: power-of-two then decimal count.
    assign pre_tick = (pre_cnt_q >= pow2_m1(div_q.exp)); // [R7]
    assign pwm_tick = pre_tick && (dec_cnt_q >= div_q.dec_m1); // [R7]

    // Both stages restart on a sync clear, so every follower ticks in phase.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_cnt_q <= '0;
            dec_cnt_q <= '0;
        end else if (sync_clr) begin
            pre_cnt_q <= '0; // [R12] [R13]
            dec_cnt_q <= '0;
        end else if (pre_tick) begin
            pre_cnt_q <= '0;
            if (pwm_tick) begin
                dec_cnt_q <= '0;
            end else begin
                dec_cnt_q <= dec_cnt_q + 4'h1;
            end
        end else begin
            pre_cnt_q <= pre_cnt_q + 7'h01;
        end
    end

    // Sync pin: resynchronise, edge detect, master pulse.
    // The edge flop resets low, the idle level of the pulled-down pin,
    // so no false edge follows reset.
    assign sync_rise = sync_s_q && !sync_prev_q && !master_q; // [R12]
    assign sync_clr  = sync_rise || cmd_sync; // [R12] [R13]

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_meta_q <= 1'b0;
            sync_s_q    <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_meta_q <= i_sync_in;
            sync_s_q    <= sync_meta_q;
            sync_prev_q <= sync_s_q;
        end
    end

    // High over counts 0..511, so its rising edge marks the wrap.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_out_q <= 1'b0;
        end else begin
            sync_out_q <= master_q && !cnt_d[CNT_HALF_BIT]; // [R11]
        end
    end

    // Period counter, 1024 ticks per period; a sync clear beats a tick.
    assign step  = pwm_tick || sync_clr;

    always_comb begin
        if (sync_clr) begin
            cnt_d = CNT_RESET; // [R12] [R13]
        end else if (pwm_tick) begin
            cnt_d = cnt_q + 10'h001; // [R4] [R5]
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= CNT_RESET; // [R9]
        end else begin
            cnt_q <= cnt_d; // [R4]
        end
    end

    // Channels: compare on the value the counter steps to.
    // This puts each switch edge in the same cycle as the counter step.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            on_raw[i]  = step && (cnt_d == on_act_q[i]);  // [R1]
            off_raw[i] = step && (cnt_d == off_act_q[i]); // [R1]
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                on_act_q[i]  <= '0;
                off_act_q[i] <= '0;
                on_shd_q[i]  <= '0;
                off_shd_q[i] <= '0;
            end
            on_pend_q  <= '0;
            off_pend_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                // Compare writes wait in a shadow, so a pulse is never cut short
                // or doubled by a value that lands in mid-period.
                // A write in the same cycle as a transfer keeps its pending flag.
                if (on_pend_q[i] && off_raw[i]) begin
                    on_act_q[i]  <= on_shd_q[i]; // [R16]
                    on_pend_q[i] <= 1'b0;
                end
                if (off_pend_q[i] && on_raw[i]) begin
                    off_act_q[i]  <= off_shd_q[i]; // [R16]
                    off_pend_q[i] <= 1'b0;
                end
                if (wb_wr && adr_ch_ok && adr_idx == 4'(i)) begin
                    if (adr_bank == BANK_ON) begin
                        on_shd_q[i]  <= CNT_W'(merge(32'(on_shd_q[i]), i_wb_dat, i_wb_sel));
                        on_pend_q[i] <= 1'b1; // [R16]
                    end else if (adr_bank == BANK_OFF) begin
                        off_shd_q[i]  <= CNT_W'(merge(32'(off_shd_q[i]), i_wb_dat, i_wb_sel));
                        off_pend_q[i] <= 1'b1; // [R16]
                    end
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            closed_q <= '1; // [R18]
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                // Off is tested first, so equal values keep the LED dark.
                if (off_raw[i] && enable_q[i]) begin
                    closed_q[i] <= 1'b1; // [R3] [R6] [R17]
                end else if (on_raw[i] && enable_q[i]) begin
                    closed_q[i] <= 1'b0; // [R2] [R6]
                end
            end
        end
    end

    // Outputs come straight from registers.
    assign o_wb_ack        = ack_q;
    assign o_wb_dat        = rdat_q;
    assign o_sync_out      = sync_out_q;
    assign o_sync_oe       = master_q; // [R10]
    assign o_bypass_closed = closed_q;
    assign o_period_count  = cnt_q;

endmodule // lbpwm_engine

// [lbpwm_pkg.sv]
// Constants, register map and types of the LED bypass PWM engine.
// How it works
// R1: Twelve channels, each with 10-bit on/off compares.
// R2: Counter equals on value: bypass switch opens.
// R3: Counter equals off value: bypass switch closes.
// R4: Counter runs 0 to 1023, then wraps.
// R5: One dimming period is 1024 PWM ticks.
// R6: Compare match acts only when channel enabled.
// R7: PWM clock: power-of-two prescaler then decimal divider.
// R8: Divider resets to total ratio of 16.
// R9: Period counter clears to zero at reset.
// R10: Master bit set drives sync pin, else input.
// R11: Master sync pulse high half period at wrap.
// R12: Follower: sync rising edge clears counter and divider.
// R13: Broadcast sync command clears counter and divider.
// R14: Only one party drives the sync line.
// R15: Host gives all devices same clock and divider.
// R16: New off waits on-match; new on waits off-match.
// R17: Equal on and off values: off wins.
// R18: Switch held closed until first enabled on match.
package lbpwm_pkg;

    localparam int          NUM_CH        = 12;
    localparam int          CNT_W         = 10;
    localparam int          ADR_W         = 8;
    localparam int          DAT_W         = 32;
    localparam logic [9:0]  CNT_RESET     = 10'h000;
    localparam int          CNT_HALF_BIT  = 9;

    // Register byte offsets.
    localparam logic [1:0]  BANK_ON       = 2'h0;
    localparam logic [1:0]  BANK_OFF      = 2'h1;
    localparam logic [7:0]  OFS_ON_BASE   = 8'h00;
    localparam logic [7:0]  OFS_OFF_BASE  = 8'h40;
    localparam logic [7:0]  OFS_ENABLE    = 8'h80;
    localparam logic [7:0]  OFS_DIVIDER   = 8'h84;
    localparam logic [7:0]  OFS_SYSTEM_CONFIGURATION    = 8'h88;
    localparam logic [7:0]  OFS_SYNC_CMD  = 8'h8c;
    localparam logic [7:0]  OFS_STATUS    = 8'h90;

    // Field positions.
    localparam int          DIV_EXP_LSB   = 0;
    localparam int          DIV_EXP_W     = 3;
    localparam int          DIV_DEC_LSB   = 8;
    localparam int          DIV_DEC_W     = 4;
    localparam int          SYSTEM_CONFIGURATION_MASTER = 0;
    localparam int          SYNC_CMD_BIT  = 0;
    localparam int          STAT_CNT_LSB  = 0;
    localparam int          STAT_SW_LSB   = 16;

    // Reset values: 2^4 times (0+1) gives a ratio of 16.
    localparam logic [2:0]  DIV_EXP_RESET = 3'h4;
    localparam logic [3:0]  DIV_DEC_RESET = 4'h0;
    localparam logic [11:0] ENABLE_RESET  = 12'h000;

    // Sync command skew across devices, in input clock cycles.
    localparam int          BCAST_SKEW_CLK = 16;

    typedef struct packed {
        logic [3:0] dec_m1;
        logic [2:0] exp;
    } lbpwm_div_type;

endpackage

// [lbpwm_properties.sv]
// Port assertions and covers for the LED bypass PWM engine.
`timescale 1ns/1ns
module lbpwm_properties
    import lbpwm_pkg::*;
(
    // Clock, reset and bus.
    input wire logic              i_core_clk,
    input wire logic              i_rstn,
    input wire logic              i_wb_cyc,
    input wire logic              i_wb_stb,
    input wire logic              o_wb_ack,
    // Sync pin, switches and counter.
    input wire logic              i_sync_in,
    input wire logic              o_sync_out,
    input wire logic              o_sync_oe,
    input wire logic [NUM_CH-1:0] o_bypass_closed,
    input wire logic [CNT_W-1:0]  o_period_count
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    a_count_step: assert property (
        $changed(o_period_count) |-> o_period_count == $past(o_period_count) + 10'h1
            || o_period_count == 10'h0) else $error("counter skipped a value");
    a_switch_step: assert property (
        $changed(o_bypass_closed) |-> $changed(o_period_count))
        else $error("switch moved without a counter step");
    a_sync_rise: assert property (
        $past(o_sync_oe, 2) && o_sync_oe && $rose(o_sync_out) |-> o_period_count == 10'h0)
        else $error("sync pulse rose away from the wrap");
    a_sync_half: assert property (
        $past(o_sync_oe) && o_sync_oe |-> o_sync_out == (o_period_count < 10'h200))
        else $error("sync pulse not in first half period");
    a_follow_clear: assert property (
        !o_sync_oe && $rose(i_sync_in) |-> ##[3:5] o_period_count == 10'h0)
        else $error("sync edge did not clear counter");
    a_ack_once: assert property (
        o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    a_ack_delay: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
    a_ack_cause: assert property (
        o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");

    c_wrap: cover property ($past(o_period_count) == 10'h3ff && o_period_count == 10'h0);
    c_master: cover property (o_sync_oe && $rose(o_sync_out));
    c_follow: cover property (!o_sync_oe && $rose(i_sync_in));
endmodule // lbpwm_properties

bind lbpwm_engine lbpwm_properties u_props (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .i_sync_in(i_sync_in), .o_sync_out(o_sync_out),
    .o_sync_oe(o_sync_oe), .o_bypass_closed(o_bypass_closed),
    .o_period_count(o_period_count));

// [lbpwm_sync_partner.sv]
// Model of the other party on the shared sync line.
`timescale 1ns/1ns
module lbpwm_sync_partner (
    // Device side of the pin.
    input  wire logic i_dev_out,
    input  wire logic i_dev_oe,
    // Host request to drive the line high.
    input  wire logic i_host_drive,
    // Resolved line level.
    output logic      o_line
);
    // The host yields while the device drives; the pull-down holds a released line low.
    assign o_line = i_dev_oe ? i_dev_out : i_host_drive;
endmodule // lbpwm_sync_partner

// [tb_top.sv]
// Self-checking bench of the LED bypass PWM engine.
`timescale 1ns/1ns
module tb_top;
    import lbpwm_pkg::*;
    logic              i_core_clk = 1'b0;
    logic              i_rstn     = 1'b0;
    logic              cyc        = 1'b0;
    logic              stb        = 1'b0;
    logic              we         = 1'b0;
    logic [7:0]        adr        = 8'h00;
    logic [31:0]       wdat       = 32'h0;
    logic              host_drive = 1'b0;
    logic [31:0]       rdat;
    logic              ack;
    logic              sync_line;
    logic              sync_out;
    logic              sync_oe;
    logic [NUM_CH-1:0] byp;
    logic [CNT_W-1:0]  cnt;
    logic [31:0]       q;
    int                c;
    int                errors     = 0;
    int                n_tests    = 0;
    int                cycles     = 0;
    logic [7:0]  r_adr [6] = '{8'h00, 8'h6c, 8'h80, 8'h88, 8'h8c, 8'ha0};
    logic [31:0] r_wd  [6] = '{32'h3ff, 32'h2aa, 32'hfff, 32'h0, 32'h0, 32'h1234};
    logic [31:0] r_exp [6] = '{32'h3ff, 32'h2aa, 32'hfff, 32'h0, 32'h0, 32'h0};

    // One clock feeds the device; the far side model takes no clock.
    initial forever #4 i_core_clk = ~i_core_clk;

    lbpwm_engine dut (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_sync_in(sync_line), .o_sync_out(sync_out), .o_sync_oe(sync_oe),
        .o_bypass_closed(byp), .o_period_count(cnt));
    lbpwm_sync_partner u_far (
        .i_dev_out(sync_out), .i_dev_oe(sync_oe), .i_host_drive(host_drive),
        .o_line(sync_line));

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge i_core_clk);
        while (ack !== 1'b1) @(posedge i_core_clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cnt(input logic [9:0] v);
        while (cnt !== v) @(posedge i_core_clk);
    endtask

    // Cycles from here to the next change of the counter.
    task automatic gap;
        logic [9:0] v;
        v = cnt;
        c = 0;
        while (cnt === v) begin
            @(posedge i_core_clk);
            c++;
        end
    endtask

    task automatic final_report;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            $display("ERROR t=%0t run too long", $time);
            final_report;
        end
    end

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        @(posedge i_core_clk);
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, r_adr[i], r_wd[i]);
            wb(1'b0, r_adr[i], 32'h0);
            chk(q, r_exp[i]);
        end
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        chk({22'h0, cnt}, 32'h0);
        chk({20'h0, byp}, 32'hfff);
        i_rstn <= 1'b1;
        @(posedge i_core_clk);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h0fff0000);
        wb(1'b0, OFS_DIVIDER, 32'h0);
        chk(q, 32'h4);
        gap;
        gap;
        chk(c, 32'd16);
        wb(1'b1, OFS_DIVIDER, 32'h100);
        gap;
        gap;
        chk(c, 32'd2);
        wait_cnt(10'h3ff);
        gap;
        chk({22'h0, cnt}, 32'h0);
        wb(1'b1, 8'h00, 32'd10);
        wb(1'b1, 8'h40, 32'd20);
        wb(1'b1, 8'h04, 32'd30);
        wb(1'b1, 8'h44, 32'd30);
        wb(1'b1, 8'h08, 32'd5);
        wb(1'b1, 8'h48, 32'd25);
        wb(1'b1, OFS_ENABLE, 32'h3);
        wait_cnt(10'h0);
        c = cycles;
        wait_cnt(10'h1);
        wait_cnt(10'h0);
        chk(cycles - c, 32'd2048);
        wait_cnt(10'd10);
        chk({31'h0, byp[0]}, 32'h0);
        chk({31'h0, byp[2]}, 32'h1);
        // A later off value written while lit must not stretch this pulse.
        wait_cnt(10'd12);
        wb(1'b1, 8'h40, 32'd100);
        wait_cnt(10'd20);
        chk({31'h0, byp[0]}, 32'h1);
        wait_cnt(10'd30);
        chk({31'h0, byp[1]}, 32'h1);
        wait_cnt(10'd0);
        wait_cnt(10'd50);
        chk({31'h0, byp[0]}, 32'h0);
        wait_cnt(10'd100);
        chk({31'h0, byp[0]}, 32'h1);
        wait_cnt(10'd600);
        wb(1'b1, OFS_SYSTEM_CONFIGURATION, 32'h1);
        chk({31'h0, sync_oe}, 32'h1);
        wait_cnt(10'd100);
        chk({31'h0, sync_out}, 32'h1);
        wait_cnt(10'd600);
        chk({31'h0, sync_out}, 32'h0);
        wb(1'b1, OFS_SYSTEM_CONFIGURATION, 32'h0);
        chk({31'h0, sync_oe}, 32'h0);
        wait_cnt(10'd300);
        host_drive <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        chk({31'h0, cnt < 10'h3}, 32'h1);
        host_drive <= 1'b0;
        wait_cnt(10'd300);
        wb(1'b1, OFS_SYNC_CMD, 32'h1);
        chk({31'h0, cnt < 10'h3}, 32'h1);
        final_report;
    end
endmodule // tb_top
